// file: verilog/sra_receiver.sv
// Asynchronous serial receiver with address detect and APB register slave
//
// Functional notes
// - Receive line sampled on a sixteen-times-baud oversampling tick.
// - Reception runs only while continuous receive enable is set.
// - After stop bit, word goes to buffer if room; ready flag follows.
// - Ready flag is read-only, clears when buffer read until empty.
// - Receive interrupt passes only when receive interrupt enable is set.
// - Buffer holds two words while a third shifts in.
// - Stop bit with buffer full sets overrun error, word discarded.
// - Overrun cleared only by clearing then setting continuous receive enable.
// - While overrun set, no words move into the buffer.
// - Framing error set when sampled stop bit is low.
// - Framing error and ninth bit kept per entry; reading buffer advances them.
// - Asynchronous mode: sync mode bit clear and serial port enable set.
// - Address detect in nine-bit mode drops data bytes without flagging.
// - Software clears address detect after its address to take all bytes.
// - Frame: start bit, eight or nine data bits LSB first, stop bit.
// - Sampling tick every divisor plus one clocks, or four times that without high-speed select.
// - Reception stops during sleep.
`timescale 1ns/1ps
`default_nettype none
`include "sra_defines.svh"

module sra_receiver (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_receive_pin,
  input wire logic sleepMode,
  output logic rxIrq
);

  // ==========================================
  // Helpers
  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  function automatic logic [7:0] wrByte(input logic [31:0] d);
    wrByte = d[7:0];
  endfunction

  // ==========================================
  // Register state
  logic [7:0] interrupt_control;
  logic [7:0] receive_status_control;
  logic [7:0] transmit_buffer;
  logic [7:0] peripheral_irq_enables;
  logic [7:0] transmit_status_control;
  logic [7:0] baud_divisor;

  logic serialPortEnable;
  logic nineBitEnable;
  logic continuousEnable;
  logic addressDetectEnable;
  logic syncMode;
  logic highSpeedBaud;
  logic rxActive;

  assign serialPortEnable = receive_status_control[`SRA_BIT_SERIAL_PORT_ENABLE];
  assign nineBitEnable = receive_status_control[`SRA_BIT_NINE_BIT_RECEIVE_ENABLE];
  assign continuousEnable = receive_status_control[`SRA_BIT_CONTINUOUS_RECEIVE_ENABLE];
  assign addressDetectEnable = receive_status_control[`SRA_BIT_ADDRESS_DETECT_ENABLE];
  assign syncMode = transmit_status_control[`SRA_BIT_SYNC_MODE];
  assign highSpeedBaud = transmit_status_control[`SRA_BIT_HIGH_SPEED_BAUD_SELECT];
  assign rxActive = serialPortEnable && !syncMode && continuousEnable && !sleepMode;

  // ==========================================
  // APB access decode
  logic setupPhase;
  logic writeDone;
  logic readDone;
  logic [9:0] regIdx;
  logic addrHit;
  logic [7:0] readValue;

  logic overrunError;
  logic [1:0] fifoFill;
  sra_pkg::sra_entry_t headEntry;
  logic receiveReadyFlag;

  assign setupPhase = psel && !penable;
  assign writeDone = psel && penable && pready && pwrite && !pslverr;
  assign readDone = psel && penable && pready && !pwrite && !pslverr;
  assign regIdx = paddr[11:2];
  assign receiveReadyFlag = fifoFill != 2'h0;

  always_comb begin
    addrHit = paddr[1:0] == 2'h0;
    readValue = 8'h00;
    if (regIdx == `SRA_IDX_INTERRUPT_CONTROL) begin
      readValue = interrupt_control;
    end else if (regIdx == `SRA_IDX_PERIPHERAL_IRQ_FLAGS) begin
      readValue[`SRA_BIT_RECEIVE_READY_FLAG] = receiveReadyFlag;
    end else if (regIdx == `SRA_IDX_RECEIVE_STATUS_CONTROL) begin
      readValue = receive_status_control;
      readValue[`SRA_BIT_FRAMING_ERROR] = headEntry.framingError;
      readValue[`SRA_BIT_OVERRUN_ERROR] = overrunError;
      readValue[`SRA_BIT_RECEIVED_NINTH_BIT] = headEntry.ninthBit;
    end else if (regIdx == `SRA_IDX_TRANSMIT_BUFFER) begin
      readValue = transmit_buffer;
    end else if (regIdx == `SRA_IDX_RECEIVE_BUFFER) begin
      readValue = headEntry.data;
    end else if (regIdx == `SRA_IDX_PERIPHERAL_IRQ_ENABLES) begin
      readValue = peripheral_irq_enables;
    end else if (regIdx == `SRA_IDX_TRANSMIT_STATUS_CONTROL) begin
      readValue = transmit_status_control;
    end else if (regIdx == `SRA_IDX_BAUD_DIVISOR) begin
      readValue = baud_divisor;
    end else begin
      addrHit = 1'b0;
    end
  end

  // ==========================================
  // APB answer: registered, no wait states
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !addrHit;
      if (setupPhase) begin
        prdata <= {24'h00_0000, readValue};
      end
    end
  end

  // ==========================================
  // Software-written registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_control <= `SRA_RST_BYTE;
      receive_status_control <= `SRA_RST_BYTE;
      transmit_buffer <= `SRA_RST_BYTE;
      peripheral_irq_enables <= `SRA_RST_BYTE;
      transmit_status_control <= `SRA_RST_TRANSMIT_STATUS_CONTROL;
      baud_divisor <= `SRA_RST_BYTE;
    end else if (writeDone) begin
      if (regIdx == `SRA_IDX_INTERRUPT_CONTROL) begin
        interrupt_control <= wrByte(pwdata) & 8'hC0;
      end else if (regIdx == `SRA_IDX_RECEIVE_STATUS_CONTROL) begin
        receive_status_control <= wrByte(pwdata) & 8'hF8;
      end else if (regIdx == `SRA_IDX_TRANSMIT_BUFFER) begin
        transmit_buffer <= wrByte(pwdata);
      end else if (regIdx == `SRA_IDX_PERIPHERAL_IRQ_ENABLES) begin
        peripheral_irq_enables <= wrByte(pwdata);
      end else if (regIdx == `SRA_IDX_TRANSMIT_STATUS_CONTROL) begin
        transmit_status_control <= (wrByte(pwdata) & `SRA_TRANSMIT_STATUS_WRITE_MASK)
          | `SRA_RST_TRANSMIT_STATUS_CONTROL;
      end else if (regIdx == `SRA_IDX_BAUD_DIVISOR) begin
        baud_divisor <= wrByte(pwdata);
      end
    end
  end

  // ==========================================
  // Receive pin synchroniser, change accepted when stages two and three agree
  logic rxSync1;
  logic rxSync2;
  logic rxSync3;
  logic rxLine;
  logic rxLinePrev;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxSync1 <= 1'b1;
      rxSync2 <= 1'b1;
      rxSync3 <= 1'b1;
      rxLine <= 1'b1;
      rxLinePrev <= 1'b1;
    end else begin
      rxSync1 <= serial_receive_pin;
      rxSync2 <= rxSync1;
      rxSync3 <= rxSync2;
      if (rxSync2 == rxSync3) begin
        rxLine <= rxSync3;
      end
      rxLinePrev <= rxLine;
    end
  end

  // ==========================================
  // Oversampling tick generator
  logic [9:0] tickCnt;
  logic [9:0] tickLimit;
  logic sampleTick;

  always_comb begin
    if (highSpeedBaud) begin
      tickLimit = {2'b00, baud_divisor};
    end else begin
      tickLimit = {baud_divisor, 2'b11};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt <= 10'h000;
      sampleTick <= 1'b0;
    end else if (!rxActive) begin
      tickCnt <= 10'h000;
      sampleTick <= 1'b0;
    end else if (tickCnt >= tickLimit) begin
      tickCnt <= 10'h000;
      sampleTick <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 10'h001;
      sampleTick <= 1'b0;
    end
  end

  // ==========================================
  // Receive sequencer
  sra_pkg::sra_state_t rxState;
  logic [3:0] phaseCnt;
  logic [3:0] bitCnt;
  logic [2:0] samples;
  logic [8:0] receive_shift_register;
  logic decideNow;
  logic sampledBit;
  logic [3:0] frameBits;

  assign decideNow = sampleTick && phaseCnt == `SRA_SAMPLE_DECIDE;
  assign sampledBit = majority3(samples);
  assign frameBits = nineBitEnable ? `SRA_DATA_BITS_9 : `SRA_DATA_BITS_8;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      samples <= 3'h7;
      phaseCnt <= 4'h0;
    end else if (rxState == sra_pkg::RX_IDLE) begin
      samples <= 3'h7;
      phaseCnt <= 4'h0;
    end else if (sampleTick) begin
      samples <= {samples[1:0], rxLine};
      phaseCnt <= phaseCnt + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= sra_pkg::RX_IDLE;
      bitCnt <= 4'h0;
      receive_shift_register <= 9'h000;
    end else if (!rxActive) begin
      rxState <= sra_pkg::RX_IDLE;
      bitCnt <= 4'h0;
    end else begin
      case (rxState)
        sra_pkg::RX_IDLE: begin
          if (rxLinePrev && !rxLine) begin
            rxState <= sra_pkg::RX_START;
          end
          bitCnt <= 4'h0;
        end
        sra_pkg::RX_START: begin
          if (decideNow) begin
            rxState <= sampledBit ? sra_pkg::RX_IDLE : sra_pkg::RX_DATA;
          end
        end
        sra_pkg::RX_DATA: begin
          if (decideNow) begin
            receive_shift_register <= {sampledBit, receive_shift_register[8:1]};
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt + 4'h1 == frameBits) begin
              rxState <= sra_pkg::RX_STOP;
            end
          end
        end
        sra_pkg::RX_STOP: begin
          if (decideNow) begin
            rxState <= sra_pkg::RX_IDLE;
          end
        end
        default: begin
          rxState <= sra_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Word completion and buffer load
  logic stopDecided;
  logic isDataByte;
  logic wordAccepted;
  logic bufferPush;
  logic bufferPop;
  sra_pkg::sra_entry_t newEntry;

  assign stopDecided = rxActive && rxState == sra_pkg::RX_STOP && decideNow;
  assign isDataByte = nineBitEnable && !receive_shift_register[8];
  assign wordAccepted = stopDecided && !overrunError
    && !(addressDetectEnable && isDataByte);
  assign bufferPush = wordAccepted && fifoFill != 2'h2;
  assign bufferPop = readDone && regIdx == `SRA_IDX_RECEIVE_BUFFER;

  always_comb begin
    newEntry.framingError = !sampledBit;
    if (nineBitEnable) begin
      newEntry.ninthBit = receive_shift_register[8];
      newEntry.data = receive_shift_register[7:0];
    end else begin
      newEntry.ninthBit = 1'b0;
      newEntry.data = receive_shift_register[8:1];
    end
  end

  // ==========================================
  // Overrun error
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrunError <= 1'b0;
    end else if (!continuousEnable) begin
      overrunError <= 1'b0;
    end else if (wordAccepted && fifoFill == 2'h2) begin
      overrunError <= 1'b1;
    end
  end

  // ==========================================
  // Receive buffer
  sra_rx_fifo u_rx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .push(bufferPush),
    .pushEntry(newEntry),
    .pop(bufferPop),
    .headEntry(headEntry),
    .fill(fifoFill)
  );

  // ==========================================
  // Interrupt request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxIrq <= 1'b0;
    end else begin
      rxIrq <= receiveReadyFlag
        && peripheral_irq_enables[`SRA_BIT_RECEIVE_IRQ_ENABLE]
        && interrupt_control[`SRA_BIT_PERIPHERAL_IRQ_GATE]
        && interrupt_control[`SRA_BIT_GLOBAL_IRQ_ENABLE];
    end
  end

endmodule

`default_nettype wire

// file: verilog/sra_defines.svh
// Register map, field positions, reset values and timing counts of the serial receiver
`ifndef SRA_DEFINES_SVH
`define SRA_DEFINES_SVH

// ==========================================
// Register indices (byte address is four times the index)
`define SRA_IDX_INTERRUPT_CONTROL 10'h00B
`define SRA_IDX_PERIPHERAL_IRQ_FLAGS 10'h00C
`define SRA_IDX_RECEIVE_STATUS_CONTROL 10'h018
`define SRA_IDX_TRANSMIT_BUFFER 10'h019
`define SRA_IDX_RECEIVE_BUFFER 10'h01A
`define SRA_IDX_PERIPHERAL_IRQ_ENABLES 10'h08C
`define SRA_IDX_TRANSMIT_STATUS_CONTROL 10'h098
`define SRA_IDX_BAUD_DIVISOR 10'h099

// ==========================================
// Field positions
`define SRA_BIT_GLOBAL_IRQ_ENABLE 7
`define SRA_BIT_PERIPHERAL_IRQ_GATE 6
`define SRA_BIT_RECEIVE_READY_FLAG 5
`define SRA_BIT_RECEIVE_IRQ_ENABLE 5
`define SRA_BIT_SERIAL_PORT_ENABLE 7
`define SRA_BIT_NINE_BIT_RECEIVE_ENABLE 6
`define SRA_BIT_SINGLE_RECEIVE_ENABLE 5
`define SRA_BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define SRA_BIT_ADDRESS_DETECT_ENABLE 3
`define SRA_BIT_FRAMING_ERROR 2
`define SRA_BIT_OVERRUN_ERROR 1
`define SRA_BIT_RECEIVED_NINTH_BIT 0
`define SRA_BIT_SYNC_MODE 4
`define SRA_BIT_HIGH_SPEED_BAUD_SELECT 2
`define SRA_BIT_TRANSMIT_SHIFT_EMPTY 1

// ==========================================
// Reset values
`define SRA_RST_BYTE 8'h00
`define SRA_RST_TRANSMIT_STATUS_CONTROL 8'h02
`define SRA_TRANSMIT_STATUS_WRITE_MASK 8'hF5

// ==========================================
// Oversampling: ticks per bit and majority sample points
`define SRA_OVERSAMPLE 5'h10
`define SRA_LOW_SPEED_PRESCALE 4'h4
`define SRA_SAMPLE_DECIDE 4'h9
`define SRA_BIT_LAST 4'hF
`define SRA_DATA_BITS_8 4'h8
`define SRA_DATA_BITS_9 4'h9

`endif

// file: verilog/sra_pkg.sv
// Types shared by the serial receiver and its receive buffer
package sra_pkg;

  // ==========================================
  // One receive buffer entry
  typedef struct packed {
    logic framingError;
    logic ninthBit;
    logic [7:0] data;
  } sra_entry_t;

  // ==========================================
  // Receive sequencer states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } sra_state_t;

endpackage

// file: verilog/sra_rx_fifo.sv
// Two-entry receive buffer; head entry is a register
`timescale 1ns/1ps
`default_nettype none

module sra_rx_fifo (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic push,
  input wire sra_pkg::sra_entry_t pushEntry,
  input wire logic pop,
  output sra_pkg::sra_entry_t headEntry,
  output logic [1:0] fill
);

  sra_pkg::sra_entry_t tailEntry;

  // ==========================================
  // Shifting storage: entry 0 is always the oldest
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      headEntry <= '0;
      tailEntry <= '0;
      fill <= 2'h0;
    end else if (pop && fill != 2'h0) begin
      if (push && fill == 2'h1) begin
        headEntry <= pushEntry;
      end else begin
        headEntry <= tailEntry;
      end
      if (push && fill == 2'h2) begin
        tailEntry <= pushEntry;
      end
      if (!push) begin
        fill <= fill - 2'h1;
      end
    end else if (push && fill != 2'h2) begin
      if (fill == 2'h0) begin
        headEntry <= pushEntry;
      end else begin
        tailEntry <= pushEntry;
      end
      fill <= fill + 2'h1;
    end
  end

endmodule

`default_nettype wire

// file: sim/sra_receiver_properties.sv
// Port-level checks for the serial receiver
`timescale 1ns/1ps
`default_nettype none
`include "sra_defines.svh"

module sra_receiver_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_receive_pin,
  input wire logic sleepMode,
  input wire logic rxIrq
);
  logic setupRd;
  assign setupRd = psel && !penable && !pwrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========
  // Bus answers
  setup_answer_a: assert property (psel && !penable |=> pready) else $error("setup not answered");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  misalign_refuse_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access accepted");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  flag_bits_a: assert property (setupRd && paddr == {`SRA_IDX_PERIPHERAL_IRQ_FLAGS, 2'h0} |=>
    (prdata[7:0] & 8'hDF) == 8'h00) else $error("flag register shows stray bits");
  tx_status_fixed_a: assert property (setupRd && paddr == {`SRA_IDX_TRANSMIT_STATUS_CONTROL, 2'h0} |=>
    prdata[1] && !prdata[3]) else $error("transmit status fixed bits wrong");
  // ==========
  // Interrupt line
  irq_fall_read_a: assert property ($fell(rxIrq) |-> pready || $past(pready) || $past(pready, 2))
    else $error("interrupt dropped without bus access");
  sleep_hold_a: assert property (sleepMode && $past(sleepMode, 3) && $rose(rxIrq) |->
    pready || $past(pready) || $past(pready, 2)) else $error("reception during sleep");
  cover property (pslverr);
  cover property ($rose(rxIrq));
  cover property ($fell(rxIrq));
endmodule

bind sra_receiver sra_receiver_checker sra_receiver_checker_i (.clock(clock), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_receive_pin(serial_receive_pin), .sleepMode(sleepMode), .rxIrq(rxIrq));
`default_nettype wire

// file: sim/sra_line_driver.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none

module sra_line_driver #(parameter int BIT_CLKS = 16) (
  input wire logic clock,
  output logic line
);
  // Clocks per bit, set by the bench for the slow sampling rate
  int bitClks = BIT_CLKS;
  initial line = 1'b1;
  task automatic send(input logic [8:0] val, input int nb, input logic stopv, input int gap);
    int i;
    @(posedge clock);
    line <= 1'b0;
    repeat (bitClks) @(posedge clock);
    for (i = 0; i < nb; i++) begin
      line <= val[i];
      repeat (bitClks) @(posedge clock);
    end
    line <= stopv; // Low only for a framing fault
    repeat (bitClks) @(posedge clock);
    line <= 1'b1;
    repeat (gap) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Register-level test of the serial receiver
`timescale 1ns/1ps
`default_nettype none
`include "sra_defines.svh"

module testbench;
  localparam logic [9:0] ICT = `SRA_IDX_INTERRUPT_CONTROL;
  localparam logic [9:0] IFL = `SRA_IDX_PERIPHERAL_IRQ_FLAGS;
  localparam logic [9:0] RCS = `SRA_IDX_RECEIVE_STATUS_CONTROL;
  localparam logic [9:0] RBF = `SRA_IDX_RECEIVE_BUFFER;
  localparam logic [9:0] PIE = `SRA_IDX_PERIPHERAL_IRQ_ENABLES;
  localparam logic [9:0] TXS = `SRA_IDX_TRANSMIT_STATUS_CONTROL;
  localparam logic [9:0] BDV = `SRA_IDX_BAUD_DIVISOR;
  localparam logic [9:0] IDX [8] = '{ICT, IFL, RCS, `SRA_IDX_TRANSMIT_BUFFER, RBF, PIE, TXS, BDV};
  localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic clock, rst_n, psel, penable, pwrite, sleepMode, pready, pslverr, rxIrq, rxLine, rde;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int err_count, checks_done, cycles;

  sra_receiver sra_receiver_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_receive_pin(rxLine), .sleepMode(sleepMode), .rxIrq(rxIrq));
  sra_line_driver sra_line_driver_i (.clock(clock), .line(rxLine));

  // ==========
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'h0}, {24'h0, d});
  endtask
  task automatic rd(input string what, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, {idx, 2'h0}, 32'h0);
    chk(what, {24'h0, exp}, rdv);
  endtask
  task automatic rx(input logic [8:0] v, input int nb, input logic stopv);
    sra_line_driver_i.send(v, nb, stopv, 40);
    repeat (6) @(posedge clock);
  endtask
  task automatic irq(input logic exp);
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, exp}, {31'h0, rxIrq});
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      finish_test;
    end
  end

  // ==========
  // Sequence
  initial begin
    {psel, penable, pwrite, sleepMode, paddr, pwdata} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int k = 0; k < 8; k++) rd("reset value", IDX[k], RST[k]);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rde});
    apb(1'b0, 12'h031, 32'h0);
    chk("misaligned err", 32'h1, {31'h0, rde});
    wr(IFL, 8'hFF);
    rd("flags ro", IFL, 8'h00);
    wr(TXS, 8'h04);
    wr(BDV, 8'h00);
    wr(ICT, 8'hC0);
    wr(PIE, 8'h20);
    wr(RCS, 8'h90);
    rx(9'h0A5, 8, 1'b1);
    rd("flags", IFL, 8'h20);
    irq(1'b1);
    sleepMode <= 1'b1;
    wr(PIE, 8'h00);
    irq(1'b0);
    wr(PIE, 8'h20);
    irq(1'b1);
    rx(9'h0E7, 8, 1'b1);
    sleepMode <= 1'b0;
    rd("status", RCS, 8'h90);
    rd("data", RBF, 8'hA5);
    rd("flags empty", IFL, 8'h00);
    irq(1'b0);
    rx(9'h03C, 8, 1'b0);
    rx(9'h0C3, 8, 1'b1);
    rd("status framing_error", RCS, 8'h94);
    rd("data", RBF, 8'h3C);
    rd("status next", RCS, 8'h90);
    rd("data", RBF, 8'hC3);
    for (int k = 1; k < 4; k++) sra_line_driver_i.send(9'(k * 17), 8, 1'b1, 0);
    repeat (6) @(posedge clock);
    rd("status overrun", RCS, 8'h92);
    rd("data", RBF, 8'h11);
    rd("data", RBF, 8'h22);
    rd("flags", IFL, 8'h00);
    rx(9'h044, 8, 1'b1);
    rd("flags blocked", IFL, 8'h00);
    wr(RCS, 8'h80);
    rx(9'h05A, 8, 1'b1);
    rd("flags off", IFL, 8'h00);
    wr(RCS, 8'h90);
    rx(9'h055, 8, 1'b1);
    rd("status cleared", RCS, 8'h90);
    rd("data", RBF, 8'h55);
    wr(RCS, 8'hD0);
    rx(9'h1AB, 9, 1'b1);
    rx(9'h0CD, 9, 1'b1);
    rd("status ninth", RCS, 8'hD1);
    rd("data", RBF, 8'hAB);
    rd("status ninth next", RCS, 8'hD0);
    rd("data", RBF, 8'hCD);
    wr(RCS, 8'hD8);
    rx(9'h077, 9, 1'b1);
    rd("flags data dropped", IFL, 8'h00);
    rx(9'h142, 9, 1'b1);
    rd("status addr", RCS, 8'hD9);
    rd("data addr", RBF, 8'h42);
    wr(RCS, 8'hD0);
    rx(9'h066, 9, 1'b1);
    rd("flags data", IFL, 8'h20);
    rd("data", RBF, 8'h66);
    wr(TXS, 8'h14);
    wr(RCS, 8'h90);
    rx(9'h0B4, 8, 1'b1);
    rd("flags sync", IFL, 8'h00);
    wr(TXS, 8'h00);
    rd("tx status slow", TXS, 8'h02);
    sra_line_driver_i.bitClks = 64;
    rx(9'h096, 8, 1'b1);
    rd("flags slow", IFL, 8'h20);
    rd("data slow", RBF, 8'h96);
    finish_test;
  end
endmodule
`default_nettype wire
